// ---- src/pmb_page_addr_protect.sv ----
`default_nettype none
module pmb_page_addr_protect (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // byte link from the bus framer
   input  wire logic       addr_valid,
   input  wire logic [6:0] addr_bits,
   input  wire logic       addr_rnw,
   output logic            addr_ack,
   input  wire logic       wr_valid,
   input  wire logic [7:0] wr_byte,
   output logic            byte_ack,
   input  wire logic       rd_req,
   output logic [7:0]      rd_byte,
   output logic            rd_valid,
   input  wire logic       pkt_stop,
   // decoded address select pins
   input  wire logic       addr_select_pin_0_open,
   input  wire logic [3:0] addr_select_pin_0_bits,
   input  wire logic       addr_select_pin_1_open,
   input  wire logic [2:0] addr_select_pin_1_bits,
   // nonvolatile image
   input  wire logic       nv_load,
   input  wire logic [7:0] nv_write_lock,
   input  wire logic [7:0] nv_config,
   input  wire logic [7:0] nv_address,
   input  wire logic [7:0] nv_rail_0,
   input  wire logic [7:0] nv_rail_1,
   // stored settings for the rest of the device
   output logic [7:0]      write_lock_level,
   output logic [7:0]      device_level_config,
   output logic            ignore_config_pins,
   output logic [7:0]      channel_select,
   // commands handled elsewhere
   output logic            ext_wr_valid,
   output logic [7:0]      ext_wr_cmd,
   output logic [7:0]      ext_wr_data,
   output logic [3:0]      ext_wr_index,
   output logic [1:0]      ext_wr_mask,
   output logic            ext_rd_req,
   output logic [7:0]      ext_rd_cmd,
   output logic            ext_rd_chan,
   input  wire logic [7:0] ext_rd_data,
   // fault report
   output logic            communication_fault,
   output logic [1:0]      fault_kind
);

   typedef struct packed {
      pmb_pkg::pmb_state_t state;
      logic [7:0]          cmd;
      logic [7:0]          tpage;
      logic                pp;
      logic                is_ppr;
      logic [3:0]          idx;
      logic                rail_pkt;
      logic [1:0]          rail_mask;
      logic                cnt_sent;
      logic [7:0]          page;
      logic [7:0]          wp;
      logic [7:0]          cfg;
      logic [7:0]          addr;
      logic [15:0]         rail;
      logic [8:0]          s1;
      logic [8:0]          s2;
      logic [8:0]          s3;
      logic [8:0]          pins;
      logic [7:0]          rd_byte;
      logic                rd_valid;
      logic                ext_wr;
      logic [7:0]          ext_cmd;
      logic [7:0]          ext_data;
      logic [3:0]          ext_idx;
      logic [1:0]          ext_mask;
      logic                fault;
      logic [1:0]          fkind;
   } pmb_st_t;

   pmb_st_t q;
   pmb_st_t d;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic wp_ok(input logic [7:0] lvl, input logic [7:0] c);
      logic base;
      logic oper;
      logic ctrl;
      base = (c == pmb_pkg::CMD_WP) || (c == pmb_pkg::CMD_PAGE) ||
             (c == pmb_pkg::CMD_STORE_ALL) || (c == pmb_pkg::CMD_NV_UNLOCK);
      oper = base || (c == pmb_pkg::CMD_OPERATION) || (c == pmb_pkg::CMD_CLR_PEAKS) ||
             (c == pmb_pkg::CMD_CLR_FAULTS) ||
             ((c >= pmb_pkg::CMD_STATUS_LO) && (c <= pmb_pkg::CMD_STATUS_HI));
      ctrl = oper || (c == pmb_pkg::CMD_ONOFF_CFG) || (c == pmb_pkg::CMD_VOUT);
      case (lvl)
         pmb_pkg::WP_ALL:  wp_ok = base;
         pmb_pkg::WP_OPER: wp_ok = oper;
         pmb_pkg::WP_CTRL: wp_ok = ctrl;
         default:          wp_ok = 1'b1;
      endcase
   endfunction

   function automatic logic is_paged(input logic [7:0] c);
      is_paged = (c == pmb_pkg::CMD_OPERATION) || (c == pmb_pkg::CMD_ONOFF_CFG) ||
                 (c == pmb_pkg::CMD_VOUT) || (c == pmb_pkg::CMD_REV) ||
                 (c == pmb_pkg::CMD_RAIL) || (c == pmb_pkg::CMD_CHAN_CFG) ||
                 (c == pmb_pkg::CMD_PWM_MODE) ||
                 ((c >= pmb_pkg::CMD_STATUS_LO) && (c <= pmb_pkg::CMD_STATUS_HI));
   endfunction

   function automatic logic [1:0] page_mask(input logic [7:0] p);
      case (p)
         pmb_pkg::PAGE_CH0: page_mask = 2'h1;
         pmb_pkg::PAGE_CH1: page_mask = 2'h2;
         pmb_pkg::PAGE_ALL: page_mask = 2'h3;
         default:           page_mask = 2'h0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic [6:0] dev_a;
   logic       dev_en;
   logic       glob_hit;
   logic       dev_hit;
   logic [1:0] rail_hit;
   logic [7:0] pg;
   logic [1:0] mask;
   logic       paged;
   logic       rch;

   always_comb begin
      d          = q;
      addr_ack   = 1'b0;
      byte_ack   = 1'b0;
      ext_rd_req = 1'b0;
      d.ext_wr   = 1'b0;
      d.rd_valid = 1'b0;
      d.fault    = 1'b0;

      // pin sync: a change counts once stages two and three agree
      d.s1 = {addr_select_pin_1_open, addr_select_pin_1_bits,
              addr_select_pin_0_open, addr_select_pin_0_bits};
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (q.s2 == q.s3) begin
         d.pins = q.s3;
      end

      // config bit 6 is deliberately not consulted here
      dev_a    = {q.pins[8] ? q.addr[6:4] : q.pins[7:5],
                  q.pins[4] ? q.addr[3:0] : q.pins[3:0]};
      dev_en   = !(q.addr[pmb_pkg::ADDR_OFF_BIT] && q.pins[8] && q.pins[4]);
      glob_hit = (addr_bits == pmb_pkg::GLOBAL_A) || (addr_bits == pmb_pkg::GLOBAL_B);
      dev_hit  = dev_en && (addr_bits == dev_a);
      for (int i = 0; i < 2; i++) begin
         rail_hit[i] = !q.rail[i*8+7] && (addr_bits == q.rail[i*8 +: 7]);
      end

      pg    = q.pp ? q.tpage : q.page;
      paged = is_paged(q.cmd);
      mask  = q.rail_pkt ? q.rail_mask : page_mask(pg);
      rch   = (pg == pmb_pkg::PAGE_CH1);

      if (addr_valid) begin
         addr_ack = glob_hit || dev_hit || (rail_hit != 2'h0);
         if (addr_ack) begin
            d.rail_pkt  = !(glob_hit || dev_hit);
            d.rail_mask = rail_hit;
            d.cnt_sent  = 1'b0;
            if (!addr_rnw) begin
               d.state  = pmb_pkg::ST_CMD;
               d.pp     = 1'b0;
               d.is_ppr = 1'b0;
               d.idx    = 4'h0;
            end else if (!(glob_hit || dev_hit)) begin
               d.fault = 1'b1;
               d.fkind = pmb_pkg::FLT_RAIL_READ;
            end
         end
      end

      if (wr_valid) begin
         byte_ack = 1'b1;
         case (q.state)
            pmb_pkg::ST_CMD: begin
               d.cmd = wr_byte;
               if (wr_byte == pmb_pkg::CMD_PPW || wr_byte == pmb_pkg::CMD_PPR) begin
                  d.pp     = 1'b1;
                  d.is_ppr = (wr_byte == pmb_pkg::CMD_PPR);
                  d.state  = pmb_pkg::ST_BCNT;
               end else begin
                  d.state = pmb_pkg::ST_DATA;
               end
            end
            pmb_pkg::ST_BCNT: begin
               d.state = pmb_pkg::ST_PPAGE;
            end
            pmb_pkg::ST_PPAGE: begin
               d.tpage = wr_byte;
               d.state = pmb_pkg::ST_PCMD;
            end
            pmb_pkg::ST_PCMD: begin
               if (wr_byte == pmb_pkg::CMD_PPW || wr_byte == pmb_pkg::CMD_PPR) begin
                  byte_ack = 1'b0;
                  d.fault  = 1'b1;
                  d.fkind  = pmb_pkg::FLT_DATA;
                  d.state  = pmb_pkg::ST_DROP;
               end else begin
                  d.cmd   = wr_byte;
                  // a read packet carries no data, so extra bytes are refused
                  d.state = q.is_ppr ? pmb_pkg::ST_DROP : pmb_pkg::ST_DATA;
               end
            end
            pmb_pkg::ST_DATA: begin
               d.idx = q.idx + 4'h1;
               if (q.idx == 4'h0 && !wp_ok(q.wp, q.cmd)) begin
                  byte_ack = 1'b0;
                  d.fault  = 1'b1;
                  d.fkind  = pmb_pkg::FLT_PROTECT;
                  d.state  = pmb_pkg::ST_DROP;
               end else if (paged && mask == 2'h0) begin
                  byte_ack = 1'b0;
                  d.fault  = 1'b1;
                  d.fkind  = pmb_pkg::FLT_DATA;
                  d.state  = pmb_pkg::ST_DROP;
               end else begin
                  case (q.cmd)
                     pmb_pkg::CMD_PAGE: begin
                        if (q.idx == 4'h0 && page_mask(wr_byte) != 2'h0) begin
                           d.page = wr_byte;
                        end else begin
                           byte_ack = 1'b0;
                        end
                     end
                     pmb_pkg::CMD_WP: begin
                        if (q.idx == 4'h0 && (wr_byte == pmb_pkg::WP_NONE || wr_byte == pmb_pkg::WP_CTRL ||
                            wr_byte == pmb_pkg::WP_OPER || wr_byte == pmb_pkg::WP_ALL)) begin
                           d.wp = wr_byte;
                        end else begin
                           byte_ack = 1'b0;
                        end
                     end
                     pmb_pkg::CMD_CFG: begin
                        if (q.idx == 4'h0) begin
                           d.cfg = wr_byte;
                        end else begin
                           byte_ack = 1'b0;
                        end
                     end
                     pmb_pkg::CMD_ADDR: begin
                        if (q.idx == 4'h0 && wr_byte <= pmb_pkg::ADDR_OFF) begin
                           d.addr = wr_byte;
                        end else begin
                           byte_ack = 1'b0;
                        end
                     end
                     pmb_pkg::CMD_RAIL: begin
                        if (q.idx == 4'h0 && wr_byte <= pmb_pkg::ADDR_OFF) begin
                           for (int i = 0; i < 2; i++) begin
                              if (mask[i]) begin
                                 d.rail[i*8 +: 8] = wr_byte;
                              end
                           end
                        end else begin
                           byte_ack = 1'b0;
                        end
                     end
                     pmb_pkg::CMD_CAP, pmb_pkg::CMD_REV: begin
                        byte_ack = 1'b0;   // read-only
                     end
                     default: begin
                        d.ext_wr   = 1'b1;
                        d.ext_cmd  = q.cmd;
                        d.ext_data = wr_byte;
                        d.ext_idx  = q.idx;
                        d.ext_mask = paged ? mask : 2'h0;
                     end
                  endcase
                  if (!byte_ack) begin
                     d.fault = 1'b1;
                     d.fkind = pmb_pkg::FLT_DATA;
                     d.state = pmb_pkg::ST_DROP;
                  end
               end
            end
            default: begin
               byte_ack = 1'b0;   // idle or dropping: refuse
            end
         endcase
      end

      if (rd_req) begin
         d.rd_valid = 1'b1;
         if (q.is_ppr && !q.cnt_sent) begin
            d.rd_byte  = pmb_pkg::PP_READ_COUNT;
            d.cnt_sent = 1'b1;
         end else begin
            case (q.cmd)
               pmb_pkg::CMD_PAGE: d.rd_byte = q.page;
               pmb_pkg::CMD_WP:   d.rd_byte = q.wp;
               pmb_pkg::CMD_CAP:  d.rd_byte = pmb_pkg::CAP_VALUE;
               pmb_pkg::CMD_REV:  d.rd_byte = pmb_pkg::REV_VALUE;
               pmb_pkg::CMD_CFG:  d.rd_byte = q.cfg;
               pmb_pkg::CMD_ADDR: d.rd_byte = q.addr;
               pmb_pkg::CMD_RAIL: d.rd_byte = rch ? q.rail[15:8] : q.rail[7:0];
               default: begin
                  ext_rd_req = 1'b1;
                  d.rd_byte  = ext_rd_data;
               end
            endcase
         end
      end

      if (pkt_stop) begin
         d.state = pmb_pkg::ST_IDLE;
         d.pp    = 1'b0;
      end

      if (nv_load) begin
         d.wp   = nv_write_lock;
         d.cfg  = nv_config;
         d.addr = nv_address;
         d.rail = {nv_rail_1, nv_rail_0};
      end

      if (!rstn) begin
         d       = '0;
         d.state = pmb_pkg::ST_IDLE;
         d.page  = pmb_pkg::RST_PAGE;
         d.wp    = pmb_pkg::RST_WP;
         d.cfg   = pmb_pkg::RST_CFG;
         d.addr  = pmb_pkg::RST_ADDR;
         d.rail  = {pmb_pkg::RST_RAIL, pmb_pkg::RST_RAIL};
         d.s1    = 9'h110;
         d.s2    = 9'h110;
         d.s3    = 9'h110;
         d.pins  = 9'h110;
      end
   end

   always_ff @(posedge clk) begin
      q <= d;
   end

   ////////////////////////////////////////////////////////////////////////////
   assign rd_byte             = q.rd_byte;
   assign rd_valid            = q.rd_valid;
   assign write_lock_level    = q.wp;
   assign device_level_config = q.cfg;
   assign ignore_config_pins  = q.cfg[pmb_pkg::CFG_IGNORE_BIT];
   assign channel_select      = q.page;
   assign ext_wr_valid        = q.ext_wr;
   assign ext_wr_cmd          = q.ext_cmd;
   assign ext_wr_data         = q.ext_data;
   assign ext_wr_index        = q.ext_idx;
   assign ext_wr_mask         = q.ext_mask;
   assign ext_rd_cmd          = q.cmd;
   assign ext_rd_chan         = rch;
   assign communication_fault = q.fault;
   assign fault_kind          = q.fkind;

endmodule
`default_nettype wire

// ---- shared/pmb_pkg.sv ----
`default_nettype none
package pmb_pkg;
   // command codes handled here
   localparam logic [7:0] CMD_PAGE       = 8'h00;
   localparam logic [7:0] CMD_OPERATION  = 8'h01;
   localparam logic [7:0] CMD_ONOFF_CFG  = 8'h02;
   localparam logic [7:0] CMD_CLR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_PPW        = 8'h05;
   localparam logic [7:0] CMD_PPR        = 8'h06;
   localparam logic [7:0] CMD_WP         = 8'h10;
   localparam logic [7:0] CMD_STORE_ALL  = 8'h15;
   localparam logic [7:0] CMD_CAP        = 8'h19;
   localparam logic [7:0] CMD_VOUT       = 8'h21;
   localparam logic [7:0] CMD_STATUS_LO  = 8'h78;
   localparam logic [7:0] CMD_STATUS_HI  = 8'h80;
   localparam logic [7:0] CMD_REV        = 8'h98;
   localparam logic [7:0] CMD_NV_UNLOCK  = 8'hbd;
   localparam logic [7:0] CMD_CHAN_CFG   = 8'hd0;
   localparam logic [7:0] CMD_CFG        = 8'hd1;
   localparam logic [7:0] CMD_PWM_MODE   = 8'hd4;
   localparam logic [7:0] CMD_CLR_PEAKS  = 8'he3;
   localparam logic [7:0] CMD_ADDR       = 8'he6;
   localparam logic [7:0] CMD_RAIL       = 8'hfa;
   // channel selector values
   localparam logic [7:0] PAGE_CH0       = 8'h00;
   localparam logic [7:0] PAGE_CH1       = 8'h01;
   localparam logic [7:0] PAGE_ALL       = 8'hff;
   // write lock levels
   localparam logic [7:0] WP_NONE        = 8'h00;
   localparam logic [7:0] WP_CTRL        = 8'h20;
   localparam logic [7:0] WP_OPER        = 8'h40;
   localparam logic [7:0] WP_ALL         = 8'h80;
   // addressing
   localparam logic [7:0] ADDR_OFF       = 8'h80;
   localparam logic [6:0] GLOBAL_A       = 7'h5a;
   localparam logic [6:0] GLOBAL_B       = 7'h5b;
   localparam int         ADDR_OFF_BIT   = 7;
   // reset values and constant reports
   localparam logic [7:0] RST_PAGE       = 8'h00;
   localparam logic [7:0] RST_WP         = 8'h00;
   localparam logic [7:0] RST_CFG        = 8'h01;
   localparam logic [7:0] RST_ADDR       = 8'h4f;
   localparam logic [7:0] RST_RAIL       = 8'h80;
   localparam logic [7:0] CAP_VALUE      = 8'hb0;
   localparam logic [7:0] REV_VALUE      = 8'h22;
   localparam logic [7:0] PP_READ_COUNT  = 8'h01;
   localparam int         CFG_IGNORE_BIT = 6;
   // fault kinds
   localparam logic [1:0] FLT_DATA       = 2'h0;
   localparam logic [1:0] FLT_PROTECT    = 2'h1;
   localparam logic [1:0] FLT_RAIL_READ  = 2'h2;
   // packet parser states, gray along idle-cmd-count-page-inner
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_CMD   = 3'h1,
      ST_BCNT  = 3'h3,
      ST_PPAGE = 3'h2,
      ST_PCMD  = 3'h6,
      ST_DATA  = 3'h7,
      ST_DROP  = 3'h5
   } pmb_state_t;
endpackage
`default_nettype wire

// ---- verification/pmb_page_addr_protect_properties.sv ----
`default_nettype none
module pmb_page_addr_protect_props (
   // clock and reset
   input wire logic       clk,
   input wire logic       rstn,
   // byte link
   input wire logic       addr_valid,
   input wire logic [6:0] addr_bits,
   input wire logic       addr_ack,
   input wire logic       wr_valid,
   input wire logic [7:0] wr_byte,
   input wire logic       byte_ack,
   input wire logic       rd_req,
   input wire logic [7:0] rd_byte,
   input wire logic       rd_valid,
   input wire logic       pkt_stop,
   input wire logic       nv_load,
   // stored settings and faults
   input wire logic [7:0] write_lock_level,
   input wire logic [7:0] device_level_config,
   input wire logic       ignore_config_pins,
   input wire logic [7:0] channel_select,
   input wire logic       communication_fault,
   input wire logic [1:0] fault_kind
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////
   sequence s_lock_cmd;
      wr_valid && byte_ack && wr_byte == pmb_pkg::CMD_WP;
   endsequence
   sequence s_next_byte;
      !addr_valid && !pkt_stop ##1 wr_valid;
   endsequence
   a_global_ack: assert property (addr_valid && addr_bits inside {7'h5a, 7'h5b} |-> addr_ack)
      else $error("global address not acknowledged");
   a_lock_legal: assert property (write_lock_level inside {8'h00, 8'h20, 8'h40, 8'h80})
      else $error("write lock holds an unsupported level");
   a_page_legal: assert property (channel_select inside {8'h00, 8'h01, 8'hff})
      else $error("channel selector holds an unsupported value");
   a_ignore_bit: assert property (ignore_config_pins == device_level_config[pmb_pkg::CFG_IGNORE_BIT])
      else $error("pin ignore flag differs from config bit");
   a_nack_fault: assert property (communication_fault && fault_kind != 2'h2 |->
      $past(wr_valid && !byte_ack))
      else $error("data fault without a refused byte");
   a_keep_state: assert property (communication_fault && fault_kind == 2'h1 |->
      $stable(device_level_config) && $stable(channel_select))
      else $error("locked write changed stored state");
   a_rd_timing: assert property (rd_valid == $past(rd_req))
      else $error("read byte not one cycle after request");
   a_rd_hold: assert property (!rd_req |=> $stable(rd_byte))
      else $error("read byte moved without a request");
   a_lock_update: assert property (s_lock_cmd ##1 s_next_byte ##0 byte_ack && !nv_load |=>
      write_lock_level == $past(wr_byte))
      else $error("accepted lock value not stored");
   a_locked_cfg: assert property (write_lock_level == 8'h80 && wr_valid && byte_ack && wr_byte == 8'hd1
      ##1 s_next_byte |-> !byte_ack)
      else $error("config write accepted under full lock");
endmodule
bind pmb_page_addr_protect pmb_page_addr_protect_props u_props (.clk, .rstn, .addr_valid, .addr_bits, .addr_ack,
   .wr_valid, .wr_byte, .byte_ack, .rd_req, .rd_byte, .rd_valid, .pkt_stop, .nv_load, .write_lock_level,
   .device_level_config, .ignore_config_pins, .channel_select, .communication_fault, .fault_kind);
`default_nettype wire

// ---- verification/pmb_host_model.sv ----
`default_nettype none
module pmb_host_model (
   // clock
   input  wire logic       clk,
   // link toward the device
   output logic            addr_valid,
   output logic [6:0]      addr_bits,
   output logic            addr_rnw,
   output logic            wr_valid,
   output logic [7:0]      wr_byte,
   output logic            rd_req,
   output logic            pkt_stop,
   input  wire logic       addr_ack,
   input  wire logic       byte_ack,
   input  wire logic [7:0] rd_byte
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {addr_valid, addr_rnw, wr_valid, rd_req, pkt_stop} = 5'h0;
      addr_bits = 7'h00;
      wr_byte = 8'h00;
   end
   // k: 0 write address, 1 read address, 2 byte, 3 stop; one strobe per packet step
   task automatic xfer(input logic [1:0] k, input logic [7:0] v, output logic ack);
      @(posedge clk);
      #1;
      addr_valid = (k < 2'h2);
      addr_rnw = k[0];
      addr_bits = v[6:0];
      wr_valid = (k == 2'h2);
      wr_byte = v;
      pkt_stop = (k == 2'h3);
      @(posedge clk);
      ack = (k < 2'h2) ? addr_ack : byte_ack;
      #1;
      {addr_valid, wr_valid, pkt_stop} = 3'h0;
      // released lines show the inverse
      addr_bits = ~addr_bits;
      wr_byte = ~wr_byte;
   endtask
   // reads only after a read address to device or global target
   task automatic rd(output logic [7:0] d);
      @(posedge clk);
      #1;
      rd_req = 1'b1;
      @(posedge clk);
      #1;
      rd_req = 1'b0;
      d = rd_byte;
   endtask
endmodule
`default_nettype wire

// ---- verification/pmb_page_addr_protect_tb.sv ----
`default_nettype none
module pmb_page_addr_protect_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [6:0] dev_a = 7'h42;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic addr_valid, addr_rnw, addr_ack, wr_valid, byte_ack, rd_req, rd_valid, pkt_stop;
   logic [6:0] addr_bits;
   logic [7:0] wr_byte, rd_byte;
   logic addr_select_pin_0_open = 1'b1;
   logic addr_select_pin_1_open = 1'b1;
   logic [3:0] addr_select_pin_0_bits = 4'h0;
   logic [2:0] addr_select_pin_1_bits = 3'h0;
   logic nv_load = 1'b0;
   logic [7:0] nv_write_lock = 8'h00;
   logic [7:0] nv_config = 8'h41;
   logic [7:0] nv_address = 8'h42;
   logic [7:0] nv_rail_0 = 8'h80;
   logic [7:0] nv_rail_1 = 8'h80;
   logic [7:0] write_lock_level, device_level_config, channel_select, ext_wr_cmd, ext_wr_data, ext_rd_cmd, ext_rd_data;
   logic ignore_config_pins, ext_wr_valid, ext_rd_req, ext_rd_chan, communication_fault;
   logic [3:0] ext_wr_index;
   logic [1:0] ext_wr_mask, fault_kind, last_kind;
   logic [7:0] cmds [5] = '{8'h00, 8'h01, 8'h78, 8'h02, 8'hd1};
   int need [5] = '{0, 1, 1, 2, 3};
   int num_errors = 0;
   int checked = 0;
   int n_ew = 0;
   int n_flt = 0;
   int cyc = 0;
   always #20 clk = ~clk;
   // far side echoes command and channel
   assign ext_rd_data = {ext_rd_cmd[6:0], ext_rd_chan};
   pmb_page_addr_protect u_pmb_page_addr_protect (.clk, .rstn, .addr_valid, .addr_bits, .addr_rnw, .addr_ack,
      .wr_valid, .wr_byte, .byte_ack, .rd_req, .rd_byte, .rd_valid, .pkt_stop, .addr_select_pin_0_open,
      .addr_select_pin_0_bits, .addr_select_pin_1_open, .addr_select_pin_1_bits, .nv_load, .nv_write_lock,
      .nv_config, .nv_address, .nv_rail_0, .nv_rail_1, .write_lock_level, .device_level_config,
      .ignore_config_pins, .channel_select, .ext_wr_valid, .ext_wr_cmd, .ext_wr_data, .ext_wr_index,
      .ext_wr_mask, .ext_rd_req, .ext_rd_cmd, .ext_rd_chan, .ext_rd_data, .communication_fault, .fault_kind);
   pmb_host_model u_pmb_host_model (.clk, .addr_valid, .addr_bits, .addr_rnw, .wr_valid, .wr_byte, .rd_req,
      .pkt_stop, .addr_ack, .byte_ack, .rd_byte);
   ////////////////////////////////////////
   task automatic report_and_stop();
      if (num_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (ext_wr_valid === 1'b1) n_ew++;
      if (communication_fault === 1'b1) begin
         n_flt++;
         last_kind = fault_kind;
      end
      if (cyc == 5000) begin
         $display("MISMATCH %0t run did not finish", $time);
         num_errors++;
         report_and_stop();
      end
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h0, got}, {7'h0, exp});
   endtask
   task automatic fchk(input int f0, input logic [1:0] kd);
      chk1(n_flt == f0 + 1, 1'b1);
      chk8({6'h0, last_kind}, {6'h0, kd});
   endtask
   // write packet: address, n bytes from the top of b, stop; the AND of the address and byte acks must match ok
   task automatic pkt(input logic [6:0] a, input int n, input logic [47:0] b, input logic ok);
      logic k;
      logic all;
      u_pmb_host_model.xfer(2'h0, {1'b0, a}, all);
      for (int i = 0; i < n; i++) begin
         u_pmb_host_model.xfer(2'h2, b[47-8*i -: 8], k);
         all &= k;
      end
      u_pmb_host_model.xfer(2'h3, 8'h00, k);
      chk1(all, ok);
   endtask
   task automatic rdp(input logic [6:0] a, input int n, input logic [47:0] b, input logic [7:0] exp);
      logic k;
      logic [7:0] d;
      u_pmb_host_model.xfer(2'h0, {1'b0, a}, k);
      for (int i = 0; i < n; i++) u_pmb_host_model.xfer(2'h2, b[47-8*i -: 8], k);
      u_pmb_host_model.xfer(2'h1, {1'b0, a}, k);
      u_pmb_host_model.rd(d);
      if (b[47:40] === pmb_pkg::CMD_PPR) begin
         chk8(d, pmb_pkg::PP_READ_COUNT);
         u_pmb_host_model.rd(d);
      end
      u_pmb_host_model.xfer(2'h3, 8'h00, k);
      chk8(d, exp);
   endtask
   ////////////////////////////////////////
   initial begin
      logic [7:0] lv;
      int f0;
      int e0;
      repeat (2) @(posedge clk);
      #1 rstn = 1'b1;
      chk8(channel_select, 8'h00);
      chk8(write_lock_level, 8'h00);
      chk8(device_level_config, 8'h01);
      nv_load = 1'b1;
      @(posedge clk);
      #1 nv_load = 1'b0;
      chk8(device_level_config, 8'h41);
      chk1(ignore_config_pins, 1'b1);
      repeat (4) @(posedge clk);
      pkt(dev_a, 0, 48'h0, 1'b1);
      pkt(7'h4f, 0, 48'h0, 1'b0);
      pkt(7'h5a, 0, 48'h0, 1'b1);
      pkt(7'h5b, 0, 48'h0, 1'b1);
      {addr_select_pin_0_open, addr_select_pin_1_open, addr_select_pin_0_bits, addr_select_pin_1_bits} = 9'h03b;
      repeat (6) @(posedge clk);
      pkt(7'h37, 0, 48'h0, 1'b1);
      pkt(dev_a, 0, 48'h0, 1'b0);
      {addr_select_pin_0_open, addr_select_pin_1_open} = 2'b11;
      repeat (6) @(posedge clk);
      pkt(dev_a, 0, 48'h0, 1'b1);
      pkt(dev_a, 2, {8'he6, 8'h80, 32'h0}, 1'b1);
      pkt(dev_a, 0, 48'h0, 1'b0);
      f0 = n_flt;
      pkt(7'h5a, 2, {8'he6, 8'h81, 32'h0}, 1'b0);
      fchk(f0, pmb_pkg::FLT_DATA);
      pkt(7'h5a, 2, {8'he6, 8'h42, 32'h0}, 1'b1);
      rdp(dev_a, 1, {8'h98, 40'h0}, 8'h22);
      rdp(dev_a, 1, {8'h19, 40'h0}, 8'hb0);
      rdp(dev_a, 1, {8'hd1, 40'h0}, 8'h41);
      f0 = n_flt;
      pkt(dev_a, 2, {8'h19, 8'h00, 32'h0}, 1'b0);
      fchk(f0, pmb_pkg::FLT_DATA);
      pkt(dev_a, 2, {8'hd1, 8'h01, 32'h0}, 1'b1);
      chk1(ignore_config_pins, 1'b0);
      pkt(dev_a, 2, {8'h00, 8'h01, 32'h0}, 1'b1);
      f0 = n_flt;
      pkt(dev_a, 2, {8'h00, 8'h02, 32'h0}, 1'b0);
      fchk(f0, pmb_pkg::FLT_DATA);
      chk8(channel_select, 8'h01);
      pkt(dev_a, 2, {8'h00, 8'hff, 32'h0}, 1'b1);
      pkt(dev_a, 2, {8'h21, 8'h55, 32'h0}, 1'b1);
      chk8({2'h0, ext_wr_mask, ext_wr_index}, 8'h30);
      chk8(ext_wr_data, 8'h55);
      rdp(dev_a, 1, {8'h21, 40'h0}, 8'h42);
      pkt(dev_a, 2, {8'h00, 8'h01, 32'h0}, 1'b1);
      rdp(dev_a, 1, {8'h21, 40'h0}, 8'h43);
      e0 = n_ew;
      pkt(dev_a, 5, {8'h05, 8'h03, 8'h00, 8'h21, 8'h66, 8'h00}, 1'b1);
      chk8({ext_wr_mask, 6'h0}, 8'h40);
      chk8(ext_wr_cmd, 8'h21);
      chk1(n_ew == e0 + 1, 1'b1);
      chk8(channel_select, 8'h01);
      pkt(dev_a, 5, {8'h05, 8'h03, 8'h07, 8'hd1, 8'h05, 8'h00}, 1'b1);
      chk8(device_level_config, 8'h05);
      for (int j = 0; j < 2; j++) begin
         f0 = n_flt;
         pkt(dev_a, 5, {8'h05, 8'h03, 8'h00, 8'h05 + j[7:0], 8'h00, 8'h00}, 1'b0);
         fchk(f0, pmb_pkg::FLT_DATA);
      end
      rdp(dev_a, 4, {8'h06, 8'h02, 8'h00, 8'h21, 16'h0}, 8'h42);
      chk8(channel_select, 8'h01);
      for (int l = 0; l < 3; l++) begin
         lv = (l == 0) ? 8'h80 : (l == 1) ? 8'h40 : 8'h20;
         pkt(dev_a, 2, {8'h10, lv, 32'h0}, 1'b1);
         chk8(write_lock_level, lv);
         if (l == 0) pkt(dev_a, 5, {8'h05, 8'h03, 8'h00, 8'h21, 8'h77, 8'h00}, 1'b0);
         for (int c = 0; c < 5; c++) begin
            f0 = n_flt;
            e0 = n_ew;
            pkt(dev_a, 2, {cmds[c], 8'h01, 32'h0}, l >= need[c]);
            if (l < need[c]) begin
               fchk(f0, pmb_pkg::FLT_PROTECT);
               chk1(n_ew == e0, 1'b1);
            end
         end
      end
      chk8(device_level_config, 8'h05);
      pkt(dev_a, 2, {8'h10, 8'h30, 32'h0}, 1'b0);
      pkt(dev_a, 2, {8'h10, 8'h00, 32'h0}, 1'b1);
      rdp(dev_a, 1, {8'h10, 40'h0}, 8'h00);
      pkt(7'h30, 0, 48'h0, 1'b0);
      pkt(dev_a, 2, {8'hfa, 8'h30, 32'h0}, 1'b1);
      pkt(7'h30, 2, {8'h21, 8'h12, 32'h0}, 1'b1);
      chk8({ext_wr_mask, ext_wr_data[5:0]}, 8'h92);
      report_and_stop();
   end
endmodule
`default_nettype wire
